/* File: core/charge_monitor.v */
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"

module charge_monitor (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // charger enable as resolved from the enable bit and polarity
    input wire enabled,
    // charge engine state and events
    input wire [1:0] charge_state,
    input wire charge_done_evt,
    input wire recharge_done_evt,
    input wire precharge_timeout_evt,
    input wire fastcharge_timeout_evt,
    // fault levels
    input wire battery_missing,
    input wire charge_error,
    input wire battery_overvoltage,
    input wire input_overvoltage,
    input wire input_undervoltage,
    input wire termination_current_hit,
    // register images
    output wire [7:0] status_byte,
    output wire [7:0] fault_byte
);

    reg done_q;
    reg recharge_q;
    reg [1:0] timeout_q;
    reg [1:0] state_q;
    reg enabled_q;
    reg [4:0] fault_q;
    reg term_q;

    // ==========================================================
    // history bits: set wins over the clear that disabling causes
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_q <= 1'b0;
            recharge_q <= 1'b0;
            timeout_q <= `TMO_NONE;
            term_q <= 1'b0;
        end
        else
        begin
            done_q <= charge_done_evt | (done_q & enabled);
            recharge_q <= recharge_done_evt | (recharge_q & enabled);
            term_q <= termination_current_hit | (term_q & enabled);
            // first timeout seen is kept until the charger is disabled
            if (timeout_q == `TMO_NONE || !enabled)
            begin
                if (precharge_timeout_evt)
                    timeout_q <= `TMO_PRECHARGE;
                else if (fastcharge_timeout_evt)
                    timeout_q <= `TMO_FASTCHARGE;
                else
                    timeout_q <= `TMO_NONE;
            end
        end
    end

    // ==========================================================
    // live fields follow their sources one cycle late
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= 2'h0;
            enabled_q <= 1'b0;
            fault_q <= 5'h00;
        end
        else
        begin
            state_q <= charge_state;
            enabled_q <= enabled;
            fault_q <= {battery_missing, charge_error, battery_overvoltage,
                        input_overvoltage, input_undervoltage};
        end
    end

    assign status_byte = {done_q, recharge_q, timeout_q, 1'b0, state_q, enabled_q};
    assign fault_byte = {fault_q, 2'b00, term_q};

endmodule // charge_monitor

`default_nettype wire

/* File: core/charger_config_status_regs.v */
// Functional notes
// - with volatile-write bit 7 of 31h clear, writes to 00h-07h are dropped.
// - with 31h bit 7 set, 00h-07h writes need 0Eh bit 0 set too.
// - 31h bit 4 enables charging; polarity from 0Fh bit 7 (1 = active high).
// - 31h bit 3 picks 500mA over 100mA, only while 07h bit 0 is set.
// - status bit 7 set after a completed charge since last enable.
// - status bit 6 set after a completed re-charge since last enable.
// - status bits 5:4 give timeout: 00 none, 01 pre-charge, 10 fast-charge.
// - fault bits 7..3: battery missing, charge error, battery OV, input OV, input UV.
// - fault bit 0 set once charge current reaches termination threshold.
// - configuration image resets to the factory contents.
// - 0Eh bit 0 permits 00h-07h writes even when 0Eh bit 2 lock is set.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"

module charger_config_status_regs #(
    parameter CFG_DEPTH = 16,
    parameter CFG_AW = 4
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // two-wire serial port
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // charge engine state and events
    input wire [1:0] charge_state,
    input wire charge_done_evt,
    input wire recharge_done_evt,
    input wire precharge_timeout_evt,
    input wire fastcharge_timeout_evt,
    // fault levels
    input wire battery_missing,
    input wire charge_error,
    input wire battery_overvoltage,
    input wire input_overvoltage,
    input wire input_undervoltage,
    input wire termination_current_hit,
    // controls to the charge engine
    output reg charge_enable,
    output reg usb_current_level_select
);

    // ==========================================================
    // serial state machine, one-hot
    localparam [6:0] S_IDLE = 7'b000_0001;
    localparam [6:0] S_ADDR = 7'b000_0010;
    localparam [6:0] S_AACK = 7'b000_0100;
    localparam [6:0] S_WR = 7'b000_1000;
    localparam [6:0] S_WACK = 7'b001_0000;
    localparam [6:0] S_RD = 7'b010_0000;
    localparam [6:0] S_RACK = 7'b100_0000;

    // true for offsets held in the configuration image
    function in_cfg_image;
        input [7:0] off;
        begin
            in_cfg_image = (off <= `CFG_LAST);
        end
    endfunction

    reg [6:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg rw_q;
    reg ptr_first_q;
    reg rd_load_q;
    reg [7:0] ptr_q;
    reg scl_q;
    reg sda_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg [7:0] cfgen_q;
    reg [7:0] usb_en_shadow_q;
    reg [7:0] permit_shadow_q;
    reg [7:0] polarity_shadow_q;
    reg mem_we_q;
    reg [CFG_AW-1:0] mem_wa_q;
    reg [7:0] mem_wd_q;
    reg [7:0] rd_byte;
    wire [7:0] mem_rd_data;
    wire [7:0] status_byte;
    wire [7:0] fault_byte;
    wire [7:0] byte_in;
    wire start_seen;
    wire stop_seen;
    wire scl_rise;
    wire scl_fall;
    wire addr_match;
    wire wr_allowed;
    wire enabled_now;

    // ==========================================================
    // bus condition detection on sampled pins
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    assign start_seen = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_seen = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    assign scl_rise = scl_q & ~scl_prev_q;
    assign scl_fall = ~scl_q & scl_prev_q;
    assign byte_in = {shift_q[6:0], sda_q};

    // slave address lives in the polarity/address byte, bits 6:0
    assign addr_match = (shift_q[6:0] == polarity_shadow_q[6:0]);

    // ==========================================================
    // write permission; the lock bit of 0Eh is deliberately not consulted
    assign wr_allowed = (ptr_q <= `CFG_LAST_VOLATILE) ?
        (cfgen_q[`CFGEN_VOL_WR_BIT] & permit_shadow_q[`PERMIT_VOL_WR_BIT]) :
        1'b1;

    // resolved enable: bit equals polarity means charging is on
    assign enabled_now = (cfgen_q[`CFGEN_CHG_EN_BIT] ==
        polarity_shadow_q[`POLARITY_BIT]);

    // ==========================================================
    // read data selection by pointer
    always @*
    begin
        if (in_cfg_image(ptr_q))
            rd_byte = mem_rd_data;
        else if (ptr_q == `REG_CFG_ENABLE)
            rd_byte = cfgen_q;
        else if (ptr_q == `REG_STATUS)
            rd_byte = status_byte;
        else if (ptr_q == `REG_FAULT)
            rd_byte = fault_byte;
        else
            rd_byte = 8'h00;
    end

    // ==========================================================
    // serial engine and register writes
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= S_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            ptr_first_q <= 1'b0;
            rd_load_q <= 1'b0;
            ptr_q <= 8'h00;
            sda_oe <= 1'b0;
            cfgen_q <= `CFGEN_RESET;
            usb_en_shadow_q <= `DEF_07;
            permit_shadow_q <= `DEF_0E;
            polarity_shadow_q <= `DEF_0F;
            mem_we_q <= 1'b0;
            mem_wa_q <= {CFG_AW{1'b0}};
            mem_wd_q <= 8'h00;
        end
        else
        begin
            mem_we_q <= 1'b0;
            if (start_seen)
            begin
                // a repeated start aborts whatever was in flight
                state_q <= S_ADDR;
                bit_cnt_q <= 3'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_q <= S_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    S_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= byte_in;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7)
                            begin
                                rw_q <= sda_q;
                                state_q <= addr_match ? S_AACK : S_IDLE;
                            end
                        end
                    end
                    S_AACK, S_WACK:
                    begin
                        // first fall drives the ack, second fall ends it
                        if (scl_fall && !sda_oe)
                            sda_oe <= 1'b1;
                        else if (scl_fall)
                        begin
                            bit_cnt_q <= 3'h0;
                            if (state_q == S_AACK && rw_q)
                            begin
                                shift_q <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                                state_q <= S_RD;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                if (state_q == S_AACK)
                                    ptr_first_q <= 1'b1;
                                state_q <= S_WR;
                            end
                        end
                    end
                    S_WR:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= byte_in;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7)
                            begin
                                state_q <= S_WACK;
                                if (ptr_first_q)
                                begin
                                    ptr_q <= byte_in;
                                    ptr_first_q <= 1'b0;
                                end
                                else
                                begin
                                    ptr_q <= ptr_q + 8'h01;
                                    if (ptr_q == `REG_CFG_ENABLE)
                                        cfgen_q <= byte_in & `CFGEN_WR_MASK;
                                    else if (in_cfg_image(ptr_q) && wr_allowed)
                                    begin
                                        mem_we_q <= 1'b1;
                                        mem_wa_q <= ptr_q[CFG_AW-1:0];
                                        mem_wd_q <= byte_in;
                                        if (ptr_q == `REG_USB_ENABLE)
                                            usb_en_shadow_q <= byte_in;
                                        if (ptr_q == `REG_WR_PERMIT)
                                            permit_shadow_q <= byte_in;
                                        if (ptr_q == `REG_POLARITY)
                                            polarity_shadow_q <= byte_in;
                                    end
                                end
                            end
                        end
                    end
                    S_RD:
                    begin
                        if (scl_fall && rd_load_q)
                        begin
                            shift_q <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            rd_load_q <= 1'b0;
                        end
                        else if (scl_fall)
                            sda_oe <= ~shift_q[7];
                        else if (scl_rise)
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7)
                            begin
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= S_RACK;
                            end
                        end
                    end
                    S_RACK:
                    begin
                        // release for the host's ack bit, then continue or stop
                        if (scl_fall)
                            sda_oe <= 1'b0;
                        else if (scl_rise)
                        begin
                            bit_cnt_q <= 3'h0;
                            if (!sda_q)
                            begin
                                rd_load_q <= 1'b1;
                                state_q <= S_RD;
                            end
                            else
                                state_q <= S_IDLE;
                        end
                    end
                    default:
                    begin
                        state_q <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // outputs to the charge engine, registered
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sda_out <= 1'b0;
            charge_enable <= 1'b0;
            usb_current_level_select <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0; // open drain: only ever pulls low
            charge_enable <= enabled_now;
            usb_current_level_select <= usb_en_shadow_q[`USB_SEL_ENABLE_BIT] &
                cfgen_q[`CFGEN_USB_SEL_BIT];
        end
    end

    // ==========================================================
    // configuration image and status history
    config_image_mem #(
        .DEPTH(CFG_DEPTH),
        .AW(CFG_AW)
    ) u_cfg_mem (
        .clock(clock),
        .rst_b(rst_b),
        .wr_en(mem_we_q),
        .wr_addr(mem_wa_q),
        .wr_data(mem_wd_q),
        .rd_addr(ptr_q[CFG_AW-1:0]),
        .rd_data_q(mem_rd_data)
    );

    charge_monitor u_monitor (
        .clock(clock),
        .rst_b(rst_b),
        .enabled(charge_enable),
        .charge_state(charge_state),
        .charge_done_evt(charge_done_evt),
        .recharge_done_evt(recharge_done_evt),
        .precharge_timeout_evt(precharge_timeout_evt),
        .fastcharge_timeout_evt(fastcharge_timeout_evt),
        .battery_missing(battery_missing),
        .charge_error(charge_error),
        .battery_overvoltage(battery_overvoltage),
        .input_overvoltage(input_overvoltage),
        .input_undervoltage(input_undervoltage),
        .termination_current_hit(termination_current_hit),
        .status_byte(status_byte),
        .fault_byte(fault_byte)
    );

endmodule // charger_config_status_regs

`default_nettype wire

/* File: core/charger_defines.vh */
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// ==========================================================
// register offsets
`define REG_CFG_ENABLE 8'h31
`define REG_STATUS 8'h36
`define REG_FAULT 8'h37
`define REG_USB_ENABLE 8'h07
`define REG_WR_PERMIT 8'h0E
`define REG_POLARITY 8'h0F
`define CFG_LAST_VOLATILE 8'h07
`define CFG_LAST 8'h0F

// ==========================================================
// field positions of the volatile configuration register
`define CFGEN_VOL_WR_BIT 7
`define CFGEN_CHG_EN_BIT 4
`define CFGEN_USB_SEL_BIT 3
`define CFGEN_WR_MASK 8'h98
`define CFGEN_RESET 8'h00

// field positions of the configuration image
`define PERMIT_VOL_WR_BIT 0
`define PERMIT_LOCK_BIT 2
`define POLARITY_BIT 7
`define USB_SEL_ENABLE_BIT 0

// ==========================================================
// status field positions and timeout codes
`define ST_DONE_BIT 7
`define ST_RECHARGE_BIT 6
`define ST_TIMEOUT_HI 5
`define ST_TIMEOUT_LO 4
`define ST_STATE_HI 2
`define ST_STATE_LO 1
`define ST_ENABLED_BIT 0
`define TMO_NONE 2'h0
`define TMO_PRECHARGE 2'h1
`define TMO_FASTCHARGE 2'h2

// ==========================================================
// factory contents of the configuration image
`define DEF_00 8'hD2
`define DEF_01 8'h02
`define DEF_02 8'h0A
`define DEF_03 8'h30
`define DEF_04 8'h24
`define DEF_05 8'h05
`define DEF_07 8'h03
`define DEF_0C 8'h00
`define DEF_0E 8'h01
`define DEF_0F 8'hA4
`define DEF_UNLISTED 8'h00

`endif

/* File: core/config_image_mem.v */
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"

module config_image_mem #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    // registered read port
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_data_q
);

    // ==========================================================
    // factory contents per entry
    function [7:0] factory_value;
        input integer idx;
        begin
            case (idx)
                0: factory_value = `DEF_00;
                1: factory_value = `DEF_01;
                2: factory_value = `DEF_02;
                3: factory_value = `DEF_03;
                4: factory_value = `DEF_04;
                5: factory_value = `DEF_05;
                7: factory_value = `DEF_07;
                12: factory_value = `DEF_0C;
                14: factory_value = `DEF_0E;
                15: factory_value = `DEF_0F;
                default: factory_value = `DEF_UNLISTED;
            endcase
        end
    endfunction

    wire [7:0] entry [0:DEPTH-1];

    // one flop group per entry so each can reset to its own constant
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_entry
            // a genvar cannot be part-selected, so its address is held as a sized constant
            localparam [AW-1:0] ENTRY_ADDR = g;
            reg [7:0] val_q;
            always @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    val_q <= factory_value(g);
                else if (wr_en && wr_addr == ENTRY_ADDR)
                    val_q <= wr_data;
            end
            assign entry[g] = val_q;
        end
    endgenerate

    // read data come out of a register
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_q <= 8'h00;
        else
            rd_data_q <= entry[rd_addr];
    end

endmodule // config_image_mem

`default_nettype wire

/* File: tb/charger_regs_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module charger_regs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial pins
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    // engine controls
    input wire logic charge_enable,
    input wire logic usb_current_level_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ==========
    // serial pin timing
    a_sda_out_low: assert property (!sda_out)
        else $error("sda_out driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda_oe moved while scl high");
    a_oe_high_hold: assert property (scl [*4] |-> $stable(sda_oe))
        else $error("sda_oe unstable in scl high phase");
    a_ack_min_width: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("acknowledge too short");
    // ==========
    // controls move only at the end of a written byte
    a_enable_on_write: assert property ($changed(charge_enable) |-> scl)
        else $error("charge_enable moved while scl low");
    a_usb_on_write: assert property ($changed(usb_current_level_select) |-> scl)
        else $error("usb select moved while scl low");
    a_ctl_settled: assert property (scl [*8] |->
        $stable(charge_enable) && $stable(usb_current_level_select))
        else $error("controls moved in a long scl high phase");
    a_reset_quiet: assert property ($rose(rst_b) |->
        !charge_enable && !usb_current_level_select && !sda_oe)
        else $error("outputs active after reset");
    // main scenarios
    c_enable: cover property ($rose(charge_enable));
    c_usb: cover property ($rose(usb_current_level_select));
    c_ack: cover property ($rose(sda_oe));
endmodule // charger_regs_chk
bind charger_config_status_regs charger_regs_chk chk (.clock(clock), .rst_b(rst_b),
    .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe), .charge_enable(charge_enable),
    .usb_current_level_select(usb_current_level_select));
`default_nettype wire

/* File: tb/i2c_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter int H = 8
) (
    // clock
    input wire logic clock,
    // device pull-down enable
    input wire logic sda_oe,
    // bus lines
    output var logic scl,
    output wire logic sda
);
    logic sda_h = 1'b1;
    int ack_errs = 0;
    initial scl = 1'b1;
    // open drain with pull-up: a released line reads high, never a stale value
    assign sda = sda_h & ~sda_oe;
    // ==========
    // bit level, changes only at falling clock edges
    task automatic hw(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic put(input logic b);
        scl = 1'b0;
        hw(2);
        sda_h = b;
        hw(H - 2);
        scl = 1'b1;
        hw(H);
    endtask
    task automatic get(output logic b);
        scl = 1'b0;
        sda_h = 1'b1;
        hw(H);
        scl = 1'b1;
        hw(H / 2);
        b = sda;
        hw(H / 2);
    endtask
    task automatic edge4(input logic a, input logic b);
        scl = 1'b0;
        hw(H);
        sda_h = a;
        hw(H);
        scl = 1'b1;
        hw(H);
        sda_h = b;
        hw(H);
    endtask
    // ==========
    // byte level and whole transfers
    task automatic tx(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--)
            put(b[i]);
        get(a);
        if (a !== 1'b0)
            ack_errs++;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        edge4(1'b1, 1'b0);
        tx(8'h48);
        tx(off);
        tx(d);
        edge4(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        edge4(1'b1, 1'b0);
        tx(8'h48);
        tx(off);
        edge4(1'b1, 1'b0);
        tx(8'h49);
        for (int i = 7; i >= 0; i--)
            get(d[i]);
        put(1'b1);
        edge4(1'b0, 1'b1);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic scl, sda, sda_out, sda_oe, charge_enable, usb_current_level_select;
    logic [1:0] charge_state = 2'h0;
    logic [3:0] evt = 4'h0;
    logic [5:0] flt = 6'h0;
    logic [7:0] rd;
    logic [15:0] dflt [10] = '{16'h00d2, 16'h0102, 16'h020a, 16'h0330, 16'h0424,
        16'h0505, 16'h0703, 16'h0c00, 16'h0e01, 16'h0fa4};
    // {expected enable, polarity byte, enable byte}; bits 6:0 keep the bus address
    logic [16:0] pol [4] = '{17'h1_2400, 17'h0_2410, 17'h0_a400, 17'h1_a410};
    int errors = 0;
    int num_checks = 0;
    always #2.5 clock = ~clock;
    i2c_host_model host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    charger_config_status_regs dut (.clock(clock), .rst_b(rst_b), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .charge_state(charge_state),
        .charge_done_evt(evt[3]), .recharge_done_evt(evt[2]),
        .precharge_timeout_evt(evt[1]), .fastcharge_timeout_evt(evt[0]),
        .battery_missing(flt[5]), .charge_error(flt[4]), .battery_overvoltage(flt[3]),
        .input_overvoltage(flt[2]), .input_undervoltage(flt[1]),
        .termination_current_hit(flt[0]), .charge_enable(charge_enable),
        .usb_current_level_select(usb_current_level_select));
    // ==========
    // compare and access helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] off, input logic [7:0] exp);
        host.rd(off, rd);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic [3:0] e);
        @(negedge clock);
        evt = e;
        @(negedge clock);
        evt = 4'h0;
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========
    // hang guard: the longest run is far below this bound
    initial
    begin
        repeat (100000) @(posedge clock);
        errors++;
        end_sim();
    end
    // ==========
    // main sequence
    initial
    begin
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        foreach (dflt[i]) rdchk(dflt[i][15:8], dflt[i][7:0]);
        rdchk(8'h36, 8'h00);
        rdchk(8'h40, 8'h00);
        host.wr(8'h00, 8'h55);
        rdchk(8'h00, 8'hd2);
        $display("test defaults done");
        // enable bit against each polarity
        foreach (pol[i])
        begin
            host.wr(8'h31, pol[i][7:0]);
            host.wr(8'h0f, pol[i][15:8]);
            chk({7'h0, charge_enable}, {7'h0, pol[i][16]});
            rdchk(8'h36, {7'h0, pol[i][16]});
        end
        $display("test polarity done");
        host.wr(8'h31, 8'h08);
        chk({7'h0, usb_current_level_select}, 8'h01);
        host.wr(8'h31, 8'h98);
        host.wr(8'h0e, 8'h05);
        host.wr(8'h07, 8'h02);
        chk({7'h0, usb_current_level_select}, 8'h00);
        rdchk(8'h07, 8'h02);
        host.wr(8'h00, 8'h77);
        rdchk(8'h00, 8'h77);
        host.wr(8'h0e, 8'h04);
        host.wr(8'h00, 8'h11);
        rdchk(8'h00, 8'h77);
        $display("test volatile writes done");
        // history, timeouts and state, the clear on disable, then faults
        host.wr(8'h31, 8'h10);
        charge_state = 2'h2;
        pulse(4'he);
        rdchk(8'h36, 8'hd5);
        host.wr(8'h31, 8'h00);
        rdchk(8'h36, 8'h04);
        host.wr(8'h31, 8'h10);
        charge_state = 2'h3;
        pulse(4'h1);
        rdchk(8'h36, 8'h27);
        flt = 6'h3f;
        rdchk(8'h37, 8'hf9);
        flt = 6'h00;
        rdchk(8'h37, 8'h01);
        chk(host.ack_errs[7:0], 8'h00);
        $display("test status and faults done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
